// ===== verilog/fws_pkg.sv
// shared constants and types for the flash status poller
package fws_pkg;

	// ------------------------------------------------------------------
	// data bus bit positions of status flags
	// ------------------------------------------------------------------
	localparam int POLL_POS   = 7;
	localparam int TOG1_POS   = 6;
	localparam int TOUT_POS   = 5;
	localparam int ETMR_POS   = 3;
	localparam int TOG2_POS   = 2;
	localparam int BABT_POS   = 1;

	// ------------------------------------------------------------------
	// register map of the controller
	// ------------------------------------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_DATA   = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_RDATA  = 4'h4;

	// ctrl bits: start, mode (0 toggle, 1 polling), erase op, reset, abort reset
	localparam int CTRL_START = 0;
	localparam int CTRL_MODE  = 1;
	localparam int CTRL_ERASE = 2;
	localparam int CTRL_RST   = 3;
	localparam int CTRL_ABRST = 4;

	// status bits
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_FAIL    = 2;
	localparam int ST_ABORT   = 3;
	localparam int ST_ETMR    = 4;

	// ------------------------------------------------------------------
	// flash commands
	// ------------------------------------------------------------------
	localparam logic [15:0] CMD_UNLK1  = 16'h00AA;
	localparam logic [15:0] CMD_UNLK2  = 16'h0055;
	localparam logic [15:0] CMD_RESET  = 16'h00F0;
	localparam logic [15:0] CMD_ABRST  = 16'h00F0;
	localparam logic [25:0] ADR_UNLK1  = 26'h0000555;
	localparam logic [25:0] ADR_UNLK2  = 26'h00002AA;

	// ------------------------------------------------------------------
	// bus cycle timing
	// ------------------------------------------------------------------
	localparam int MCLK_MHZ   = 125;
	localparam int T_ACC_NS   = 120;
	localparam int T_HI_NS    = 30;
	localparam int ACC_CYC    = (T_ACC_NS * MCLK_MHZ + 999) / 1000;
	localparam int HI_CYC     = (T_HI_NS * MCLK_MHZ + 999) / 1000;
	localparam logic [4:0] ACC_CNT = 5'(ACC_CYC);
	localparam logic [4:0] HI_CNT  = 5'(HI_CYC);

	typedef struct packed {
		logic        cs_b;
		logic        oe_b;
		logic        we_b;
		logic [25:0] addr;
	} fws_bus_s;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_RD1   = 3'b001,
		S_RD2   = 3'b011,
		S_CHK   = 3'b010,
		S_RD3   = 3'b110,
		S_CMD   = 3'b101,
		S_FIN   = 3'b100
	} fws_state_e;

endpackage

// ===== verilog/fws_cycle.sv
// single flash bus cycle engine, read or write
`timescale 1ns/100ps
module fws_cycle
	import fws_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        go,
	input  wire logic        wr,
	input  wire logic [25:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [15:0] dq_in,
	output fws_bus_s         bus,
	output logic [15:0]      dq_out,
	output logic             dq_oe_b,
	output logic             done,
	output logic [15:0]      rdata
);
	import fws_pkg::*;

	logic        act_q, act_d;
	logic        hi_q, hi_d;
	logic [4:0]  cnt_q, cnt_d;
	fws_bus_s    bus_q, bus_d;
	logic [15:0] dout_q, dout_d, rd_q, rd_d;
	logic        oe_q, oe_d, done_q, done_d;

	always_comb begin
		act_d  = act_q;
		hi_d   = hi_q;
		cnt_d  = cnt_q;
		bus_d  = bus_q;
		dout_d = dout_q;
		rd_d   = rd_q;
		oe_d   = oe_q;
		done_d = 1'b0;
		if (!act_q && go) begin
			act_d     = 1'b1;
			hi_d      = 1'b0;
			cnt_d     = ACC_CNT;
			bus_d     = '{cs_b: 1'b0, oe_b: wr, we_b: !wr, addr: addr};
			dout_d    = wdata;
			oe_d      = !wr;
		end else if (act_q && cnt_q != 5'h00) begin
			cnt_d = cnt_q - 5'h01;
		end else if (act_q && !hi_q) begin
			// RULE10 release between reads
			// strobes released between cycles so toggle bits advance
			if (!bus_q.oe_b)
				rd_d = dq_in;
			bus_d.cs_b = 1'b1;
			bus_d.oe_b = 1'b1;
			bus_d.we_b = 1'b1;
			hi_d       = 1'b1;
			cnt_d      = HI_CNT;
		end else if (act_q) begin
			act_d  = 1'b0;
			oe_d   = 1'b1;
			done_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			act_q  <= 1'b0;
			hi_q   <= 1'b0;
			cnt_q  <= 5'h00;
			bus_q  <= '{cs_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, addr: 26'h0};
			dout_q <= 16'h0000;
			rd_q   <= 16'h0000;
			oe_q   <= 1'b1;
			done_q <= 1'b0;
		end else begin
			act_q  <= act_d;
			hi_q   <= hi_d;
			cnt_q  <= cnt_d;
			bus_q  <= bus_d;
			dout_q <= dout_d;
			rd_q   <= rd_d;
			oe_q   <= oe_d;
			done_q <= done_d;
		end
	end

	assign bus     = bus_q;
	assign dq_out  = dout_q;
	assign dq_oe_b = oe_q;
	assign done    = done_q;
	assign rdata   = rd_q;
endmodule

// ===== verilog/fws_poller.sv
// host side status poller for program and erase completion
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
// Operation
// RULE1 - device outputs inverted programmed bit until program completes
// RULE2 - polling valid after last write; buffer mode only at last word
// RULE3 - host reads polling status at the programmed address
// RULE4 - erase gives zero on polling bit, one when done or suspended
// RULE5 - all-protected erase shows busy about 100 us then reads array
// RULE6 - protected program address toggles about 1 us, no programming
// RULE7 - toggle bit one inverts per read while operation runs
// RULE8 - all-protected erase toggles bit one about 100 us
// RULE9 - toggle one stops in suspend, resumes during suspended program
// RULE10 - toggle advances only across separate strobed read cycles
// RULE11 - toggle bit two inverts in sectors selected for erase
// RULE12 - polling bit may turn valid before other bits; reread
// RULE13 - host reads status twice, unchanged toggle means finished
// RULE14 - toggling with timeout bit high: recheck, then reset command
// RULE15 - avoid other-sector reads between toggle reads; else polling
// RULE16 - timeout bit set when pulse limit exceeded
// RULE17 - zero to one programming silently masked
// RULE18 - after timeout failure host issues reset command
// RULE19 - erase timer bit zero in window, one after it
// RULE20 - timer bit one: only erase suspend accepted
// RULE21 - buffer abort bit needs dedicated abort reset sequence
// RULE22 - toggle bit one readable at any address
// RULE23 - suspended sector reads return status bits
// RULE24 - idle reads return array contents
module fws_poller
	import fws_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output fws_bus_s         flash_bus,
	output logic [15:0]      flash_dq_out,
	output logic             flash_dq_oe_b,
	input  wire logic [15:0] flash_dq_in
);
	import fws_pkg::*;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	fws_state_e  st_q, st_d;
	logic [25:0] addr_q, addr_d;
	logic [15:0] data_q, data_d;
	logic        mode_q, mode_d, erase_q, erase_d;
	logic        busy_q, busy_d, done_q, done_d;
	logic        fail_q, fail_d, abort_q, abort_d, etmr_q, etmr_d;
	logic        tout_q, tout_d;
	logic [15:0] first_q, first_d, last_q, last_d;
	logic [1:0]  cmd_q, cmd_d;
	logic        abseq_q, abseq_d;
	logic [31:0] rdata_q, rdata_d;
	logic        go_q, go_d, wr_q, wr_d;
	logic [25:0] cyc_addr_q, cyc_addr_d;
	logic [15:0] cyc_data_q, cyc_data_d;
	logic        cyc_done;
	logic [15:0] cyc_rdata;
	logic        tog_moved;
	logic        poll_ok;

	fws_cycle u_cycle (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.go      (go_q),
		.wr      (wr_q),
		.addr    (cyc_addr_q),
		.wdata   (cyc_data_q),
		.dq_in   (flash_dq_in),
		.bus     (flash_bus),
		.dq_out  (flash_dq_out),
		.dq_oe_b (flash_dq_oe_b),
		.done    (cyc_done),
		.rdata   (cyc_rdata)
	);

	// RULE13 compare toggle bit
	assign tog_moved = (first_q[TOG1_POS] != cyc_rdata[TOG1_POS]);
	// RULE1 true datum means done; erase completes on one (RULE4)
	assign poll_ok = erase_q ? cyc_rdata[POLL_POS]
		: (cyc_rdata[POLL_POS] == data_q[POLL_POS]);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb begin
		st_d       = st_q;
		addr_d     = addr_q;
		data_d     = data_q;
		mode_d     = mode_q;
		erase_d    = erase_q;
		busy_d     = busy_q;
		done_d     = done_q;
		fail_d     = fail_q;
		abort_d    = abort_q;
		etmr_d     = etmr_q;
		tout_d     = tout_q;
		first_d    = first_q;
		last_d     = last_q;
		cmd_d      = cmd_q;
		abseq_d    = abseq_q;
		go_d       = 1'b0;
		wr_d       = 1'b0;
		cyc_addr_d = cyc_addr_q;
		cyc_data_d = cyc_data_q;
		rdata_d    = 32'h0;

		if (reg_rd) begin
			case (reg_addr)
				REG_ADDR:   rdata_d = {6'h00, addr_q};
				REG_DATA:   rdata_d = {16'h0000, data_q};
				REG_STATUS: begin
					rdata_d[ST_BUSY]  = busy_q;
					rdata_d[ST_DONE]  = done_q;
					rdata_d[ST_FAIL]  = fail_q;
					rdata_d[ST_ABORT] = abort_q;
					rdata_d[ST_ETMR]  = etmr_q;
				end
				REG_RDATA:  rdata_d = {16'h0000, last_q};
				default:    rdata_d = 32'h0;
			endcase
		end

		if (reg_wr && st_q == S_IDLE) begin
			case (reg_addr)
				REG_ADDR: addr_d = reg_wdata[25:0];
				REG_DATA: data_d = reg_wdata[15:0];
				REG_CTRL: begin
					mode_d  = reg_wdata[CTRL_MODE];
					erase_d = reg_wdata[CTRL_ERASE];
					if (reg_wdata[CTRL_START]) begin
						busy_d = 1'b1;
						done_d = 1'b0;
						fail_d = 1'b0;
						tout_d = 1'b0;
						st_d   = S_RD1;
					end else if (reg_wdata[CTRL_RST]
						|| reg_wdata[CTRL_ABRST]) begin
						busy_d  = 1'b1;
						abseq_d = reg_wdata[CTRL_ABRST];
						cmd_d   = 2'h0;
						st_d    = S_CMD;
					end
				end
				default: ;
			endcase
		end

		case (st_q)
			S_IDLE: ;
			S_RD1: begin
				// RULE3 read at the programmed or erased address
				// RULE2 status read after command
				go_d       = 1'b1;
				cyc_addr_d = addr_q;
				st_d       = S_RD2;
			end
			S_RD2: if (cyc_done) begin
				first_d = cyc_rdata;
				etmr_d  = cyc_rdata[ETMR_POS];
				if (mode_q) begin
					// RULE15 polling needs no paired reads
					// RULE12 valid polling still needs a reread
					if (poll_ok) begin
						st_d = S_RD3;
						go_d = 1'b1;
					end else if (cyc_rdata[TOUT_POS] || tout_q) begin
						tout_d = 1'b1;
						st_d   = S_RD3;
						go_d   = 1'b1;
					end else begin
						st_d = S_RD1;
					end
				end else begin
					go_d = 1'b1;
					st_d = S_CHK;
				end
			end
			S_CHK: if (cyc_done) begin
				etmr_d = cyc_rdata[ETMR_POS];
				// RULE21 abort flag, seen on both reads
				// one array word with that bit set must not abort
				if (first_q[BABT_POS] && cyc_rdata[BABT_POS]
					&& tog_moved) begin
					abort_d = 1'b1;
					fail_d  = 1'b1;
					busy_d  = 1'b0;
					st_d    = S_IDLE;
				end else if (!tog_moved) begin
					st_d = S_RD3;
					go_d = 1'b1;
				end else if (tout_q) begin
					// RULE14 still toggling after timeout bit
					fail_d = 1'b1;
					abseq_d = 1'b0;
					cmd_d  = 2'h0;
					st_d   = S_CMD;
				end else begin
					// RULE16 latch timeout bit for a recheck
					tout_d  = cyc_rdata[TOUT_POS];
					first_d = cyc_rdata;
					go_d    = 1'b1;
				end
			end
			S_RD3: if (cyc_done) begin
				last_d = cyc_rdata;
				if (tout_q && mode_q) begin
					// RULE18 reset after timeout failure
					fail_d  = 1'b1;
					abseq_d = 1'b0;
					cmd_d   = 2'h0;
					st_d    = S_CMD;
				end else begin
					done_d = 1'b1;
					st_d   = S_FIN;
				end
			end
			S_CMD: begin
				if (!go_q && (cyc_done || cmd_q == 2'h0)) begin
					go_d = 1'b1;
					wr_d = 1'b1;
					case (cmd_q)
						2'h0: begin
							cyc_addr_d = ADR_UNLK1;
							cyc_data_d = CMD_UNLK1;
						end
						2'h1: begin
							cyc_addr_d = ADR_UNLK2;
							cyc_data_d = CMD_UNLK2;
						end
						default: begin
							cyc_addr_d = ADR_UNLK1;
							cyc_data_d = abseq_q ? CMD_ABRST
								: CMD_RESET;
						end
					endcase
					cmd_d = cmd_q + 2'h1;
				end
				if (cyc_done && cmd_q == 2'h3) begin
					go_d = 1'b0;
					wr_d = 1'b0;
					abort_d = 1'b0;
					st_d = S_FIN;
				end
			end
			S_FIN: begin
				busy_d = 1'b0;
				st_d   = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
		if (st_q == S_RD1 || (st_q != S_CMD && go_d))
			cyc_addr_d = addr_q;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q       <= S_IDLE;
			addr_q     <= 26'h0;
			data_q     <= 16'h0000;
			mode_q     <= 1'b0;
			erase_q    <= 1'b0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			fail_q     <= 1'b0;
			abort_q    <= 1'b0;
			etmr_q     <= 1'b0;
			tout_q     <= 1'b0;
			first_q    <= 16'h0000;
			last_q     <= 16'h0000;
			cmd_q      <= 2'h0;
			abseq_q    <= 1'b0;
			rdata_q    <= 32'h0;
			go_q       <= 1'b0;
			wr_q       <= 1'b0;
			cyc_addr_q <= 26'h0;
			cyc_data_q <= 16'h0000;
		end else begin
			st_q       <= st_d;
			addr_q     <= addr_d;
			data_q     <= data_d;
			mode_q     <= mode_d;
			erase_q    <= erase_d;
			busy_q     <= busy_d;
			done_q     <= done_d;
			fail_q     <= fail_d;
			abort_q    <= abort_d;
			etmr_q     <= etmr_d;
			tout_q     <= tout_d;
			first_q    <= first_d;
			last_q     <= last_d;
			cmd_q      <= cmd_d;
			abseq_q    <= abseq_d;
			rdata_q    <= rdata_d;
			go_q       <= go_d;
			wr_q       <= wr_d;
			cyc_addr_q <= cyc_addr_d;
			cyc_data_q <= cyc_data_d;
		end
	end

	assign reg_rdata = rdata_q;
endmodule

// ===== dv/fws_flash_model.sv
// status bit model of the flash seen from the poller
`timescale 1ns/100ps
module fws_flash_model
	import fws_pkg::*;
(
	input  fws_pkg::fws_bus_s bus,
	input  wire logic [15:0]  dq_out,
	input  wire logic         arm,
	input  int                busy_n,
	input  wire logic         erase,
	input  wire logic         tmo,
	input  wire logic         abt,
	input  wire logic [15:0]  arr,
	output logic [15:0]       dq_in,
	output int                n_wr,
	output logic [15:0]       last_wr,
	output logic [25:0]       rd_addr
);
	// ------------------------------------------------------------------
	// read and write cycle handling
	// ------------------------------------------------------------------
	int          rd_n = 0;
	logic        t1 = 1'b0;
	logic        rst_seen = 1'b0;
	logic [15:0] last = 16'h0000;
	logic [15:0] st;
	logic [15:0] cur;
	wire         act = rd_n < busy_n || ((tmo || abt) && !rst_seen);
	// polling bit valid one read early
	wire         early = rd_n + 1 == busy_n && !tmo && !abt;
	wire         sel = !bus.cs_b && !bus.oe_b;
	wire         wsel = !bus.cs_b && !bus.we_b;

	initial n_wr = 0;

	always @(posedge arm) begin
		rd_n = 0;
		rst_seen = 1'b0;
	end

	always_comb begin
		st = 16'h0000;
		st[POLL_POS] = early ? arr[POLL_POS]
			: erase ? 1'b0 : ~arr[POLL_POS];
		st[TOG1_POS] = t1;
		// set only by the pulse limit
		st[TOUT_POS] = tmo && rd_n >= busy_n;
		st[ETMR_POS] = erase;
		st[BABT_POS] = abt && rd_n >= busy_n;
		st[TOG2_POS] = erase & t1;
	end

	// status while busy, else array data
	assign cur = act ? st : arr;
	// released bus shows the inverse, never a stale value
	assign dq_in = sel ? cur : ~last;

	always @(negedge sel) begin
		last = cur;
		rd_addr = bus.addr;
		if (act)
			t1 = ~t1;
		rd_n = rd_n + 1;
	end

	// reset command ends a failed operation
	always @(negedge wsel) begin
		n_wr = n_wr + 1;
		last_wr = dq_out;
		if (dq_out[7:0] == 8'hF0)
			rst_seen = 1'b1;
	end
endmodule

// ===== dv/fws_poller_properties.sv
// bus timing properties of the status poller
`timescale 1ns/100ps
module fws_poller_properties
	import fws_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic [3:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input fws_pkg::fws_bus_s flash_bus,
	input wire logic [15:0] flash_dq_out,
	input wire logic        flash_dq_oe_b,
	input wire logic [15:0] flash_dq_in
);
	// ------------------------------------------------------------------
	// strobe length counter and properties
	// ------------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [4:0] lo_q;
	logic [4:0] lo_d;
	always_comb lo_d = flash_bus.oe_b ? 5'h00 : lo_q + 5'h01;
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			lo_q <= 5'h00;
		else
			lo_q <= lo_d;

	sequence s_rd_hold;
		!flash_bus.oe_b && $past(!flash_bus.oe_b);
	endsequence
	sequence s_wr_low8;
		(!flash_bus.we_b)[*8];
	endsequence

	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_rd_length: assert property ($rose(flash_bus.oe_b) |-> lo_q == 5'h10)
		else $error("read strobe length wrong");
	a_rd_gap: assert property (
		$rose(flash_bus.oe_b) |-> (flash_bus.oe_b)[*5])
		else $error("read strobe high time too short");
	a_rd_addr: assert property (s_rd_hold |-> $stable(flash_bus.addr))
		else $error("address moved during read");
	a_wr_data: assert property (
		$past(!flash_bus.we_b) && !flash_bus.we_b |-> $stable(flash_dq_out))
		else $error("write data moved during strobe");
	a_wr_length: assert property ($fell(flash_bus.we_b) |-> s_wr_low8)
		else $error("write strobe too short");
	a_no_clash: assert property (
		!flash_bus.oe_b |-> flash_bus.we_b && flash_dq_oe_b && !flash_bus.cs_b)
		else $error("bus contention during read");
	a_wr_drive: assert property (
		!flash_bus.we_b |-> !flash_dq_oe_b && !flash_bus.cs_b)
		else $error("write without driving data");
endmodule

bind fws_poller fws_poller_properties chk_u (
	.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .flash_bus(flash_bus),
	.flash_dq_out(flash_dq_out), .flash_dq_oe_b(flash_dq_oe_b),
	.flash_dq_in(flash_dq_in));

// ===== dv/fws_poller_bench.sv
// self-checking bench for the flash status poller
`timescale 1ns/100ps
module fws_poller_bench;
	import fws_pkg::*;
	logic        mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, s;
	fws_bus_s    flash_bus;
	logic [15:0] dq_out, dq_in, last_wr, m_arr = 16'h0000;
	logic        dq_oe_b, m_arm = 1'b0, m_erase = 1'b0, m_tmo = 1'b0;
	logic        m_abt = 1'b0;
	logic [25:0] m_rd_a;
	int          m_busy = 0, n_wr, n_errors = 0, n_tests = 0;

	always #4 mclk = ~mclk;

	fws_poller dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flash_bus(flash_bus),
		.flash_dq_out(dq_out), .flash_dq_oe_b(dq_oe_b),
		.flash_dq_in(dq_in));
	fws_flash_model mdl_u (.bus(flash_bus), .dq_out(dq_out), .arm(m_arm),
		.busy_n(m_busy), .erase(m_erase), .tmo(m_tmo), .arr(m_arr),
		.abt(m_abt), .dq_in(dq_in), .n_wr(n_wr), .last_wr(last_wr),
		.rd_addr(m_rd_a));

	// ------------------------------------------------------------------
	// bus tasks and checks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1 s = reg_rdata;
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			rd(REG_STATUS);
			k++;
		end while (s[ST_BUSY] !== 1'b0 && k < 3000);
		chk("busy", 32'h0, {31'h0, s[ST_BUSY]});
	endtask
	task automatic run(input logic md, er, to, input int bz,
		input logic [15:0] d);
		int w0;
		w0 = n_wr;
		m_busy  <= bz;
		m_erase <= er;
		m_tmo   <= to;
		m_arr   <= d;
		m_arm   <= 1'b1;
		wr(REG_ADDR, 32'h0000_0040);
		m_arm   <= 1'b0;
		wr(REG_DATA, {16'h0000, d});
		wr(REG_CTRL, {27'h0, 2'b00, er, md, 1'b1});
		// refused while busy, else the check never settles
		wr(REG_DATA, {16'h0000, ~d});
		wait_idle();
		chk("fail", {31'h0, to}, {31'h0, s[ST_FAIL]});
		chk("read addr", 32'h40, {6'h00, m_rd_a});
		if (er)
			chk("erase timer", 32'h1, {31'h0, s[ST_ETMR]});
		if (!to) begin
			chk("done", 32'h1, {31'h0, s[ST_DONE]});
			rd(REG_RDATA);
			chk("rdata", {16'h0000, d}, s);
		end else if (!md)
			chk("reset writes", 32'd3, 32'(n_wr - w0));
	endtask
	task automatic cmd(input int bit_n);
		int w0;
		w0 = n_wr;
		wr(REG_CTRL, 32'h1 << bit_n);
		wait_idle();
		chk("cmd writes", 32'd3, 32'(n_wr - w0));
		chk("cmd code", {16'h0000, CMD_RESET}, {16'h0000, last_wr});
	endtask
	task automatic abort_run();
		m_busy  <= 2;
		m_erase <= 1'b0;
		m_tmo   <= 1'b0;
		m_abt   <= 1'b1;
		m_arr   <= 16'h0F0F;
		m_arm   <= 1'b1;
		wr(REG_ADDR, 32'h0000_0040);
		m_arm   <= 1'b0;
		wr(REG_CTRL, 32'h0000_0001);
		wait_idle();
		chk("abort", 32'h1, {31'h0, s[ST_ABORT]});
		chk("abort fail", 32'h1, {31'h0, s[ST_FAIL]});
		cmd(CTRL_ABRST);
		chk("abort clear", 32'h0, {31'h0, s[ST_ABORT]});
		m_abt   <= 1'b0;
	endtask
	task automatic give_verdict();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		void'($urandom(1071));
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		rd(4'hF);
		chk("unmapped", 32'h0, s);
		run(1'b1, 1'b0, 1'b0, 3, 16'h5A3C);
		run(1'b0, 1'b0, 1'b0, 4, 16'h00A5);
		run(1'b0, 1'b0, 1'b0, 0, 16'h0000);
		run(1'b1, 1'b1, 1'b0, 5, 16'hFFFF);
		run(1'b0, 1'b1, 1'b0, 2, 16'hFFFF);
		run(1'b0, 1'b0, 1'b1, 3, 16'h1234);
		run(1'b1, 1'b0, 1'b1, 2, 16'h0081);
		cmd(CTRL_RST);
		cmd(CTRL_ABRST);
		abort_run();
		for (int i = 0; i < 6; i++)
			run(1'($urandom), 1'b0, 1'b0, $urandom % 8, 16'($urandom));
		give_verdict();
	end

	initial begin
		#(60000 * 8);
		n_errors++;
		give_verdict();
	end
endmodule
